// file: msa_adc_dev.sv
// Purpose: Digital sequencer of the 16-channel 14-bit SAR converter
// Assumes: All link pins and the comparator are asynchronous to clk_i
// Notes:   Conversion clock is sampled, not used as a clock
//
// The implementer's own choices: the register offsets and strobed register access.

`timescale 1ns/1ps

module msa_adc_dev
  import msa_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  // Link to controller
  msa_link_if.dev                link,
  // Analog front end
  input  wire logic              cmp_i,
  output logic [ADDR_W-1:0]      mux_sel_o,
  output logic                   mux_en_o,
  output logic                   track_o,
  output logic [SEG_W-1:0]       coarse_seg_o,
  output logic [FINE_W-1:0]      fine_code_o
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = 4 + ADDR_W;

  logic [SW-1:0] s1_q, s1_d, s2_q, s2_d;
  logic          cclk_s3_q, cclk_s3_d;
  logic          start_s3_q, start_s3_d;

  logic cclk_s, en_s, start_s, oe_s, cmp_s;
  logic [ADDR_W-1:0] addr_s;

  always_comb begin
    s1_d       = {link.conv_clk, link.en, link.start_convert, link.oe, link.addr};
    s2_d       = s1_q;
    cclk_s3_d  = cclk_s;
    start_s3_d = start_s;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_q       <= '0;
      s2_q       <= '0;
      cclk_s3_q  <= 1'b0;
      start_s3_q <= 1'b0;
    end else if (ce_i) begin
      s1_q       <= s1_d;
      s2_q       <= s2_d;
      cclk_s3_q  <= cclk_s3_d;
      start_s3_q <= start_s3_d;
    end
  end

  assign {cclk_s, en_s, start_s, oe_s, addr_s} = s2_q;

  // Comparator is analog, synchronised separately
  logic cmp_s1_q, cmp_s2_q;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
    end else if (ce_i) begin
      cmp_s1_q <= cmp_i;
      cmp_s2_q <= cmp_s1_q;
    end
  end

  assign cmp_s = cmp_s2_q;

  logic cclk_rise, start_rise;
  assign cclk_rise  = cclk_s & ~cclk_s3_q;
  assign start_rise = start_s & ~start_s3_q;

  // ****************************************
  // Conversion sequencer
  // ****************************************
  msa_state_t        state_q, state_d;
  logic [4:0]        cnt_q, cnt_d;
  logic              pend_q, pend_d;
  logic [ADDR_W-1:0] ch_q, ch_d;
  logic [RES_W-1:0]  sar_q, sar_d;
  logic [RES_W-1:0]  res_q, res_d;
  logic              eoc_q, eoc_d;
  logic              busy_n_q, busy_n_d;

  // Bit under trial for a given edge index
  function automatic logic [RES_W-1:0] bit_mask(input logic [4:0] idx);
    logic [4:0] pos;
    // Edge index one below the counter: MSB trial is placed at SAMP_CYC - 1
    pos = 5'(TRIAL_END - 1) - idx;
    bit_mask = RES_W'(1) << pos;
  endfunction

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    pend_d   = pend_q;
    ch_d     = ch_q;
    sar_d    = sar_q;
    res_d    = res_q;
    eoc_d    = eoc_q;
    busy_n_d = busy_n_q;

    // Starts during a conversion are dropped, not queued
    if (start_rise && state_q == MSA_IDLE && en_s) begin
      pend_d = 1'b1;
    end

    if (!en_s) begin
      // Sleep aborts; logic state is suspect until a full cycle runs
      state_d  = MSA_IDLE;
      pend_d   = 1'b0;
      busy_n_d = 1'b1;
      cnt_d    = '0;
    end else if (cclk_rise) begin
      cnt_d = cnt_q + 5'd1;
      case (state_q)
        MSA_IDLE: begin
          cnt_d = '0;
          if (pend_q) begin
            pend_d   = 1'b0;
            ch_d     = addr_s;
            sar_d    = '0;
            eoc_d    = 1'b0;
            busy_n_d = 1'b0;
            state_d  = MSA_SAMPLE;
          end
        end
        MSA_SAMPLE: begin
          if (cnt_q == 5'(SAMP_CYC - 1)) begin
            sar_d   = bit_mask(5'(SAMP_CYC - 1));
            state_d = MSA_TRIAL;
          end
        end
        MSA_TRIAL: begin
          if (!cmp_s) begin
            sar_d = sar_q & ~bit_mask(cnt_q - 5'd1);
          end
          if (cnt_q == 5'(TRIAL_END)) begin
            state_d = MSA_FINISH;
          end else begin
            sar_d = sar_d | bit_mask(cnt_q);
          end
        end
        MSA_FINISH: begin
          if (cnt_q == 5'(CONV_CYC - 1)) begin
            res_d    = sar_q;
            eoc_d    = 1'b1;
            busy_n_d = 1'b1;
            state_d  = MSA_IDLE;
          end
        end
        default: begin
          state_d = MSA_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q  <= MSA_IDLE;
      cnt_q    <= '0;
      pend_q   <= 1'b0;
      ch_q     <= '0;
      sar_q    <= '0;
      res_q    <= '0;
      eoc_q    <= 1'b0;
      busy_n_q <= 1'b1;
    end else if (ce_i) begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      pend_q   <= pend_d;
      ch_q     <= ch_d;
      sar_q    <= sar_d;
      res_q    <= res_d;
      eoc_q    <= eoc_d;
      busy_n_q <= busy_n_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.busy_n   = busy_n_q;
  assign link.eoc      = eoc_q;
  assign link.data_out = res_q;
  assign link.data_oe  = oe_s;

  assign mux_sel_o    = ch_q;
  assign mux_en_o     = en_s;
  assign track_o      = (state_q == MSA_SAMPLE);
  assign coarse_seg_o = sar_q[RES_W-1:FINE_W];
  assign fine_code_o  = sar_q[FINE_W-1:0];

endmodule

// file: msa_pkg.sv
// Purpose: Shared constants for the multiplexed SAR converter and its controller
// Assumes: 100 MHz system clock, conversion clock made by the controller
// Notes:   Controller register offsets are byte addresses on the plain port

package msa_pkg;

  // ****************************************
  // Converter geometry
  // ****************************************
  localparam int RES_W    = 14;
  localparam int ADDR_W   = 4;
  localparam int CH_N     = 16;
  localparam int SEG_W    = 4;
  localparam int FINE_W   = 10;

  // ****************************************
  // Conversion sequence, in conversion clocks
  // ****************************************
  localparam int CONV_CYC  = 20;
  localparam int SAMP_CYC  = 3;
  localparam int TRIAL_END = SAMP_CYC + RES_W - 1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 10;
  localparam int CONV_CLK_NS = 1000;
  localparam int HALF_CNT    = CONV_CLK_NS / (2 * CLK_NS);
  localparam int START_HOLD  = 4;
  localparam int READ_HOLD   = 8;

  // ****************************************
  // Controller registers
  // ****************************************
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHAN   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;

  localparam int CTRL_EN    = 0;
  localparam int CTRL_CONT  = 1;
  localparam int CTRL_OE    = 2;
  localparam int CTRL_START = 3;

  localparam int ST_DONE  = 0;
  localparam int ST_DROP  = 1;
  localparam int ST_BUSY  = 8;
  localparam int ST_EOC   = 9;
  localparam int ST_WAKE  = 10;
  localparam int EVT_W    = 2;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    MSA_IDLE   = 2'b00,
    MSA_SAMPLE = 2'b01,
    MSA_TRIAL  = 2'b11,
    MSA_FINISH = 2'b10
  } msa_state_t;

endpackage

// file: msa_link_if.sv
// Purpose: Pin-level link between converter and controller
// Assumes: Data lines idle high while nobody drives them
// Notes:   Pull-up stands for the released shared bus

`timescale 1ns/1ps

interface msa_link_if;
  import msa_pkg::*;

  logic              conv_clk;
  logic              en;
  logic              start_convert;
  logic [ADDR_W-1:0] addr;
  logic              oe;
  logic              busy_n;
  logic              eoc;
  logic [RES_W-1:0]  data_out;
  logic              data_oe;
  logic [RES_W-1:0]  data_bus;

  // Released bus reads as all ones
  assign data_bus = data_oe ? data_out : {RES_W{1'b1}};

  modport dev (
    input  conv_clk, en, start_convert, addr, oe,
    output busy_n, eoc, data_out, data_oe
  );

  modport ctl (
    output conv_clk, en, start_convert, addr, oe,
    input  busy_n, eoc, data_bus
  );
endinterface

// file: msa_adc_ctl.sv
// Purpose: Controller driving the converter link from software registers
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   First result after wake-up is dropped, not returned

`timescale 1ns/1ps

module msa_adc_ctl
  import msa_pkg::*;
#(
  parameter int HALF = HALF_CNT
)(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o,
  // Link to converter
  msa_link_if.ctl          link
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [RES_W+1:0] s1_q, s2_q;
  logic             eoc_s3_q;
  logic             busy_n_s, eoc_s;
  logic [RES_W-1:0] data_s;

  // Idle pin levels, so no false busy shows right after reset
  localparam logic [RES_W+1:0] SYNC_IDLE = {1'b1, 1'b0, {RES_W{1'b1}}};

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s1_q     <= SYNC_IDLE;
      s2_q     <= SYNC_IDLE;
      eoc_s3_q <= 1'b0;
    end else if (ce_i) begin
      s1_q     <= {link.busy_n, link.eoc, link.data_bus};
      s2_q     <= s1_q;
      eoc_s3_q <= eoc_s;
    end
  end

  assign {busy_n_s, eoc_s, data_s} = s2_q;

  // ****************************************
  // Registers and link control
  // ****************************************
  logic [31:0]       ctrl_q, ctrl_d;
  logic [ADDR_W-1:0] chan_q, chan_d;
  logic [EVT_W-1:0]  stat_q, stat_d;
  logic [EVT_W-1:0]  mask_q, mask_d;
  logic [RES_W-1:0]  data_q, data_d;
  logic [3:0]        start_q, start_d;
  logic [3:0]        rd_q, rd_d;
  logic              wake_q, wake_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [15:0]       div_q, div_d;
  logic              cclk_q, cclk_d;
  logic [EVT_W-1:0]  evt;

  always_comb begin
    ctrl_d  = ctrl_q;
    chan_d  = chan_q;
    mask_d  = mask_q;
    data_d  = data_q;
    start_d = (start_q != 4'd0) ? start_q - 4'd1 : start_q;
    rd_d    = (rd_q != 4'd0) ? rd_q - 4'd1 : rd_q;
    wake_d  = wake_q;
    evt     = '0;
    rdata_d = '0;
    div_d   = div_q + 16'd1;
    cclk_d  = cclk_q;

    // Free-running conversion clock
    if (div_q == 16'(HALF - 1)) begin
      div_d  = '0;
      cclk_d = ~cclk_q;
    end

    if (eoc_s && !eoc_s3_q) begin
      if (wake_q) begin
        wake_d         = 1'b0;
        evt[ST_DROP]   = 1'b1;
      end else begin
        rd_d = 4'(READ_HOLD);
      end
    end
    // Bus settled through both synchronisers by now
    if (rd_q == 4'd1) begin
      data_d        = data_s;
      evt[ST_DONE]  = 1'b1;
    end

    if (we_i) begin
      case (addr_i)
        OFS_CTRL: begin
          if (wdata_i[CTRL_EN] && !ctrl_q[CTRL_EN]) begin
            wake_d = 1'b1;
          end
          ctrl_d = wdata_i & 32'h0000_0007;
          if (wdata_i[CTRL_START]) begin
            start_d = 4'(START_HOLD);
          end
        end
        OFS_CHAN: chan_d = wdata_i[ADDR_W-1:0];
        OFS_MASK: mask_d = wdata_i[EVT_W-1:0];
        default: begin
        end
      endcase
    end

    // Set wins over the write-one clear
    stat_d = stat_q;
    if (we_i && addr_i == OFS_STATUS) begin
      stat_d = stat_q & ~wdata_i[EVT_W-1:0];
    end
    stat_d = stat_d | evt;

    if (re_i) begin
      case (addr_i)
        OFS_CTRL:   rdata_d = ctrl_q;
        OFS_CHAN:   rdata_d = {28'h0, chan_q};
        OFS_STATUS: rdata_d = {21'h0, wake_q, eoc_s, ~busy_n_s, 6'h0, stat_q};
        OFS_MASK:   rdata_d = {30'h0, mask_q};
        OFS_DATA:   rdata_d = {18'h0, data_q};
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q  <= CTRL_RST;
      chan_q  <= '0;
      stat_q  <= '0;
      mask_q  <= MASK_RST[EVT_W-1:0];
      data_q  <= '0;
      start_q <= '0;
      rd_q    <= '0;
      wake_q  <= 1'b0;
      rdata_q <= '0;
      div_q   <= '0;
      cclk_q  <= 1'b0;
    end else if (ce_i) begin
      ctrl_q  <= ctrl_d;
      chan_q  <= chan_d;
      stat_q  <= stat_d;
      mask_q  <= mask_d;
      data_q  <= data_d;
      start_q <= start_d;
      rd_q    <= rd_d;
      wake_q  <= wake_d;
      rdata_q <= rdata_d;
      div_q   <= div_d;
      cclk_q  <= cclk_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Continuous: start follows busy; a start write pulls it low to kick off
  assign link.start_convert = ctrl_q[CTRL_CONT] ? (busy_n_s & (start_q == 4'd0))
                                                : (start_q != 4'd0);
  assign link.conv_clk = cclk_q;
  assign link.en       = ctrl_q[CTRL_EN];
  assign link.addr     = chan_q;
  assign link.oe       = ctrl_q[CTRL_OE] | (rd_q != 4'd0);
  assign rdata_o       = rdata_q;
  assign irq_o         = |(stat_q & mask_q);

endmodule

// file: msa_link_checker.sv
// Purpose: Timing checks on the link between converter and controller
// Assumes: One clk_i domain, link pins sampled on it
// Notes:   HALF must match the controller instance
`timescale 1ns/1ps

module msa_link_checker
  import msa_pkg::*;
#(
  parameter int HALF = HALF_CNT
)(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              nrst_i,
  // Link pins
  input wire logic              en,
  input wire logic              start_convert,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              oe,
  input wire logic              busy_n,
  input wire logic              eoc,
  input wire logic [RES_W-1:0]  data_out,
  input wire logic              data_oe
);
  // Two sync flops plus wait for the next conversion clock edge
  localparam int START_MAX = 2 * HALF + 6;
  localparam int CONV_LEN  = CONV_CYC * 2 * HALF;
  int cnt_q;
  int cnt_d;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // ****************************************
  // Busy length counter
  // ****************************************
  always_comb cnt_d = busy_n ? 0 : cnt_q + 1;
  always_ff @(posedge clk_i) cnt_q <= nrst_i ? cnt_d : 0;

  // ****************************************
  // Assertions
  // ****************************************
  chk_conv_length: assert property ($rose(busy_n) && eoc |-> cnt_q == CONV_LEN)
    else $error("conversion length off");
  chk_addr_held: assert property (!busy_n |-> $stable(addr))
    else $error("channel changed while busy");
  chk_start_begins: assert property ($rose(start_convert) && busy_n && en |->
    ##[1:START_MAX] !busy_n)
    else $error("start edge did not begin conversion");
  chk_sleep_abort: assert property ($fell(en) |-> ##[1:5] busy_n)
    else $error("sleep did not stop conversion");
  chk_result_latch: assert property ($changed(data_out) |-> $rose(eoc))
    else $error("result changed outside end of conversion");
  chk_oe_follow: assert property ($changed(oe) |-> ##[1:4] data_oe == oe)
    else $error("output drive does not follow enable");
  chk_busy_no_eoc: assert property (!busy_n |-> !eoc)
    else $error("busy and end of conversion together");
  chk_eoc_release: assert property ($rose(eoc) |-> $rose(busy_n))
    else $error("end of conversion without busy release");
  chk_eoc_fall: assert property ($fell(eoc) |-> !busy_n)
    else $error("end of conversion fell outside a start");

  cover property ($rose(eoc));
  cover property ($fell(en) && !busy_n);
  cover property ($rose(busy_n) ##[1:START_MAX] !busy_n);
  cover property ($rose(data_oe));
endmodule

// file: mux_sar_adc_conversion_control_tb_top.sv
// Purpose: Self-checking bench for converter and controller joined by the link
// Assumes: Ideal comparator against a random target code
// Notes:   HALF shortened to 3, so a conversion takes 120 clk_i cycles
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end

module mux_sar_adc_conversion_control_tb_top
  import msa_pkg::*;
;
  localparam int HALF = 3;
  localparam logic [31:0] B_DONE = 32'h1 << ST_DONE;
  localparam logic [31:0] B_DROP = 32'h1 << ST_DROP;
  localparam logic [31:0] B_EOC  = 32'h1 << ST_EOC;

  logic              clk_i;
  logic              nrst_i;
  logic [7:0]        addr_i;
  logic [31:0]       wdata_i;
  logic              we_i;
  logic              re_i;
  logic [31:0]       rdata_o;
  logic              irq_o;
  logic              cmp_i;
  logic [ADDR_W-1:0] mux_sel_o;
  logic              mux_en_o;
  logic              track_o;
  logic [SEG_W-1:0]  coarse_seg_o;
  logic [FINE_W-1:0] fine_code_o;
  logic [RES_W-1:0]  tgt;
  logic [RES_W-1:0]  old;
  logic [ADDR_W-1:0] ch;
  logic [31:0]       exp_q[$];
  logic [31:0]       ev;
  logic              re_d;
  int                fails;
  int                comparisons;
  int                trk;
  int                i;

  // ****************************************
  // Design, link and checker
  // ****************************************
  // Keep the trial bit while the target is not below the DAC code
  assign cmp_i = ({coarse_seg_o, fine_code_o} <= tgt);

  msa_link_if u_msa_link_if ();
  msa_adc_dev u_msa_adc_dev (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .link(u_msa_link_if.dev), .cmp_i(cmp_i), .mux_sel_o(mux_sel_o), .mux_en_o(mux_en_o),
    .track_o(track_o), .coarse_seg_o(coarse_seg_o), .fine_code_o(fine_code_o));
  msa_adc_ctl #(.HALF(HALF)) u_msa_adc_ctl (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .link(u_msa_link_if.ctl));
  msa_link_checker #(.HALF(HALF)) u_msa_link_checker (.clk_i(clk_i), .nrst_i(nrst_i),
    .en(u_msa_link_if.en), .start_convert(u_msa_link_if.start_convert),
    .addr(u_msa_link_if.addr), .oe(u_msa_link_if.oe), .busy_n(u_msa_link_if.busy_n),
    .eoc(u_msa_link_if.eoc), .data_out(u_msa_link_if.data_out),
    .data_oe(u_msa_link_if.data_oe));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    re_d <= re_i;
    if (track_o === 1'b1) trk++;
    if (re_d === 1'b1) begin
      ev = exp_q.pop_front();
      `CHK(rdata_o, ev)
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Idle cycle after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i) we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr_i <= a;
    re_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i) re_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Ends after the controller has fetched the result
  task automatic conv();
    int n;
    for (n = 0; n < 300 && u_msa_link_if.busy_n !== 1'b0; n++) @(posedge clk_i);
    // A conversion that never comes counts as a mismatch
    if (n == 300) fails++;
    for (n = 0; n < 300 && u_msa_link_if.eoc !== 1'b1; n++) @(posedge clk_i);
    if (n == 300) fails++;
    repeat (16) @(posedge clk_i);
  endtask

  task automatic complete_run();
    repeat (2) @(posedge clk_i);
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    nrst_i      = 1'b0;
    addr_i      = 8'h00;
    wdata_i     = 32'h0;
    we_i        = 1'b0;
    re_i        = 1'b0;
    tgt         = '0;
    fails       = 0;
    comparisons = 0;
    trk         = 0;
    void'($urandom(80));
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    rd(OFS_CTRL, CTRL_RST);
    rd(OFS_MASK, MASK_RST);
    rd(OFS_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    `CHK(u_msa_link_if.busy_n, 1'b1)
    // First result after wake is dropped
    wr(OFS_MASK, 32'h3);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h9);
    conv();
    rd(OFS_STATUS, B_DROP | B_EOC);
    `CHK(irq_o, 1'b1)
    wr(OFS_STATUS, B_DROP);
    for (i = 0; i < 6; i++) begin
      ch = ADDR_W'($urandom);
      tgt <= RES_W'($urandom);
      wr(OFS_CHAN, 32'(ch));
      wr(OFS_MASK, i[0] ? 32'h2 : 32'h1);
      trk = 0;
      wr(OFS_CTRL, 32'h9);
      // Start while busy must be ignored
      if (i == 2) begin
        repeat (40) @(posedge clk_i);
        wr(OFS_CTRL, 32'h9);
      end
      conv();
      `CHK(mux_sel_o, ch)
      `CHK(mux_en_o, 1'b1)
      `CHK(trk, 3 * 2 * HALF)
      rd(OFS_DATA, 32'(tgt));
      rd(OFS_STATUS, B_DONE | B_EOC);
      `CHK(irq_o, !i[0])
      wr(OFS_STATUS, B_DONE);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
    end
    // Sleep mid-conversion, then the wake result is dropped
    old = tgt;
    tgt <= RES_W'($urandom);
    wr(OFS_CTRL, 32'h9);
    repeat (40) @(posedge clk_i);
    wr(OFS_CTRL, 32'h0);
    repeat (8) @(posedge clk_i);
    `CHK(u_msa_link_if.busy_n, 1'b1)
    `CHK(mux_en_o, 1'b0)
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h9);
    conv();
    rd(OFS_DATA, 32'(old));
    rd(OFS_STATUS, B_DROP | B_EOC);
    wr(OFS_STATUS, B_DROP);
    // Continuous: each end restarts the next conversion
    wr(OFS_CTRL, 32'hb);
    repeat (3) conv();
    wr(OFS_CTRL, 32'h1);
    repeat (150) @(posedge clk_i);
    rd(OFS_DATA, 32'(tgt));
    // Forced bus drive, then released bus idles high
    wr(OFS_CTRL, 32'h5);
    repeat (6) @(posedge clk_i);
    `CHK(u_msa_link_if.data_bus, tgt)
    wr(OFS_CTRL, 32'h1);
    repeat (6) @(posedge clk_i);
    `CHK(u_msa_link_if.data_bus, {RES_W{1'b1}})
    complete_run();
  end
endmodule
